// ==== hw/scr_core.v ====
`timescale 1ns/10ps
`default_nettype none
`include "scr_regs.vh"

module scr_core #(
	parameter integer HALF_CYC = `SCR_CARD_HALF_CYC,
	parameter integer ETU_CLKS = `SCR_ETU_CARD_CLKS,
	parameter integer FIFO_DEPTH = `SCR_FIFO_DEPTH,
	parameter integer FIFO_AW = `SCR_FIFO_AW
) (
	input wire clk,
	input wire system_reset_low,
	input wire [2:0] addr,
	input wire [7:0] data_in,
	output wire [7:0] data_out,
	input wire wr,
	input wire rd,
	input wire cs,
	output wire host_wr_ready,
	output wire card_rst,
	output wire card_clk,
	input wire card_io_in,
	output wire card_io_out,
	output wire card_io_oe
);

	// ****************************************************************
	// Constants and state codes.
	// ****************************************************************
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_TX = 3'b010;
	localparam [2:0] ST_RX = 3'b100;

	localparam integer HALF_LAST_I = HALF_CYC - 1;
	localparam integer ETU_LAST_I = ETU_CLKS - 1;
	localparam integer ETU_MID_I = ETU_CLKS / 2;
	localparam integer CHAR_LAST_I = `SCR_CHAR_BITS - 1;
	localparam integer DRIVEN_I = `SCR_FRAME_DRIVEN_BITS;
	localparam [15:0] HALF_LAST = HALF_LAST_I[15:0];
	localparam [9:0] ETU_LAST = ETU_LAST_I[9:0];
	localparam [9:0] ETU_MID = ETU_MID_I[9:0];
	localparam [3:0] CHAR_LAST = CHAR_LAST_I[3:0];
	localparam [3:0] DRIVEN_BITS = DRIVEN_I[3:0];

	// ****************************************************************
	// Resets and host strobes.
	// ****************************************************************
	wire hard_rst;
	wire soft_rst;
	wire wr_outgoing;
	wire wr_card_rst;
	wire rd_incoming;
	wire host_rd;

	assign hard_rst = ~system_reset_low;
	assign wr_outgoing = cs & wr & (addr == `SCR_ADDR_OUTGOING);
	assign wr_card_rst = cs & wr & (addr == `SCR_ADDR_CARD_RST);
	assign rd_incoming = cs & rd & (addr == `SCR_ADDR_INCOMING);
	assign host_rd = cs & rd;
	// A card reset write also restarts the card clock and the transfer logic.
	assign soft_rst = hard_rst | wr_card_rst;

	// ****************************************************************
	// Registers and state.
	// ****************************************************************
	reg card_rst_q;
	reg [7:0] incoming_q;
	reg done_q;
	reg [7:0] data_out_q;
	reg [15:0] div_cnt_q;
	reg card_clk_q;
	reg io_s1_q;
	reg io_s2_q;
	reg [2:0] state_q;
	reg [9:0] etu_q;
	reg [3:0] bit_q;
	reg [9:0] tx_frame_q;
	reg [7:0] rx_shift_q;
	reg done_set;

	wire card_tick;
	wire etu_end;
	wire char_end;
	wire mid_sample;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [7:0] fifo_out_data;

	// ****************************************************************
	// Card reset control.
	// ****************************************************************
	always @(posedge clk) begin
		if (hard_rst) begin
			card_rst_q <= `SCR_CARD_RST_RESET;
		end else if (wr_card_rst) begin
			card_rst_q <= data_in[`SCR_CARD_RST_BIT];
		end
	end

	assign card_rst = card_rst_q;

	// ****************************************************************
	// Card clock divider.
	// ****************************************************************
	always @(posedge clk) begin
		if (soft_rst) begin
			div_cnt_q <= 16'h0000;
			card_clk_q <= 1'b0;
		end else if (div_cnt_q == HALF_LAST) begin
			div_cnt_q <= 16'h0000;
			card_clk_q <= ~card_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	// One pulse per card clock period, on the rising card edge.
	assign card_tick = (div_cnt_q == HALF_LAST) & ~card_clk_q;
	assign card_clk = card_clk_q;

	// ****************************************************************
	// Card data input synchroniser.
	// ****************************************************************
	always @(posedge clk) begin
		if (hard_rst) begin
			io_s1_q <= 1'b1;
			io_s2_q <= 1'b1;
		end else begin
			io_s1_q <= card_io_in;
			io_s2_q <= io_s1_q;
		end
	end

	// ****************************************************************
	// Outgoing byte queue.
	// ****************************************************************
	scr_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_tx_fifo (
		.clk(clk),
		.rst(soft_rst),
		.in_valid(wr_outgoing),
		.in_ready(host_wr_ready),
		.in_data(data_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// The queue drains only between characters, so a busy line stalls it.
	// A character starts on a card clock tick, so its start bit lasts a full bit period.
	assign fifo_out_ready = (state_q == ST_IDLE) & card_tick;

	// ****************************************************************
	// Bit timing.
	// ****************************************************************
	assign etu_end = card_tick & (etu_q == ETU_LAST);
	assign char_end = etu_end & (bit_q == CHAR_LAST);
	assign mid_sample = card_tick & (etu_q == ETU_MID);

	// ****************************************************************
	// Character sequencer.
	// ****************************************************************
	always @(posedge clk) begin
		if (soft_rst) begin
			state_q <= ST_IDLE;
			etu_q <= 10'h000;
			bit_q <= 4'h0;
			tx_frame_q <= 10'h3FF;
			rx_shift_q <= 8'h00;
			done_set <= 1'b0;
		end else begin
			done_set <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					etu_q <= 10'h000;
					bit_q <= 4'h0;
					if (fifo_out_valid) begin
						if (card_tick) begin
							// Start bit low, data LSB first, even parity on top.
							tx_frame_q <= {^fifo_out_data, fifo_out_data, 1'b0};
							state_q <= ST_TX;
						end
					end else if (!io_s2_q) begin
						state_q <= ST_RX;
					end
				end
				ST_TX: begin
					if (card_tick) begin
						etu_q <= etu_end ? 10'h000 : etu_q + 10'h001;
					end
					if (etu_end) begin
						bit_q <= bit_q + 4'h1;
					end
					if (char_end) begin
						done_set <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_RX: begin
					if (card_tick) begin
						etu_q <= etu_end ? 10'h000 : etu_q + 10'h001;
					end
					if (etu_end) begin
						bit_q <= bit_q + 4'h1;
					end
					if (mid_sample) begin
						if (bit_q == 4'h0 && io_s2_q) begin
							// A glitch, not a start bit: go back to waiting.
							state_q <= ST_IDLE;
						end else if (bit_q >= 4'h1 && bit_q <= 4'h8) begin
							rx_shift_q <= {io_s2_q, rx_shift_q[7:1]};
						end
					end
					if (char_end) begin
						done_set <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Receive register.
	// ****************************************************************
	always @(posedge clk) begin
		if (hard_rst) begin
			incoming_q <= `SCR_INCOMING_RESET;
		end else if (done_set && state_q == ST_IDLE) begin
			incoming_q <= incoming_q;
		end else if (char_end && state_q == ST_RX) begin
			incoming_q <= rx_shift_q;
		end
	end

	// ****************************************************************
	// Transfer done flag.
	// ****************************************************************
	always @(posedge clk) begin
		if (hard_rst) begin
			done_q <= 1'b0;
		end else if (done_set) begin
			// A completion in the same cycle as a clear keeps the flag set.
			done_q <= 1'b1;
		end else if (wr_outgoing || rd_incoming || wr_card_rst) begin
			done_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Card data line drive.
	// ****************************************************************
	// The line is driven for start, data and parity, and released for guard time.
	assign card_io_oe = (state_q == ST_TX) && (bit_q < DRIVEN_BITS);
	assign card_io_out = card_io_oe ? tx_frame_q[bit_q] : 1'b1;

	// ****************************************************************
	// Host read data.
	// ****************************************************************
	always @(posedge clk) begin
		if (hard_rst) begin
			data_out_q <= `SCR_UNMAPPED_READ;
		end else if (host_rd) begin
			case (addr)
				`SCR_ADDR_INCOMING: begin
					data_out_q <= incoming_q;
				end
				`SCR_ADDR_STATE: begin
					data_out_q <= {7'h00, done_q};
				end
				default: begin
					data_out_q <= `SCR_UNMAPPED_READ;
				end
			endcase
		end
	end

	assign data_out = data_out_q;

	// Received parity is not checked.

endmodule // scr_core

`default_nettype wire

// ==== hw/scr_regs.vh ====
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// ****************************************************************
// Register map on the three-bit host address.
// ****************************************************************
`define SCR_ADDR_OUTGOING 3'h2
`define SCR_ADDR_INCOMING 3'h3
`define SCR_ADDR_STATE 3'h4
`define SCR_ADDR_CARD_RST 3'h5

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SCR_DONE_BIT 0
`define SCR_CARD_RST_BIT 0
`define SCR_OUTGOING_RESET 8'h00
`define SCR_INCOMING_RESET 8'h00
`define SCR_STATE_RESET 8'h00
`define SCR_CARD_RST_RESET 1'b0
`define SCR_UNMAPPED_READ 8'h00

// ****************************************************************
// Timing: system clock, card clock and character framing.
// ****************************************************************
`define SCR_CLK_PERIOD_NS 10
`define SCR_CARD_PERIOD_NS 1000
`define SCR_CARD_HALF_CYC (`SCR_CARD_PERIOD_NS / (2 * `SCR_CLK_PERIOD_NS))
`define SCR_ETU_CARD_CLKS 372
`define SCR_CHAR_BITS 11
`define SCR_FRAME_DRIVEN_BITS 10
`define SCR_FIFO_DEPTH 8
`define SCR_FIFO_AW 3

`endif

// ==== hw/scr_fifo.v ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Small synchronous FIFO with valid and ready on both sides.
// ****************************************************************
module scr_fifo #(
	parameter integer WIDTH = 8,
	parameter integer DEPTH = 8,
	parameter integer AW = 3
) (
	input wire clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	localparam integer LAST_I = DEPTH - 1;
	localparam [AW:0] FULL_CNT = DEPTH[AW:0];
	localparam [AW-1:0] LAST_PTR = LAST_I[AW-1:0];

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign in_ready = (count_q != FULL_CNT);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule // scr_fifo

`default_nettype wire

// ==== verification/scr_core_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checks for the card reader core.
// ****
module scr_core_sva #(
	parameter int HALF_CYC = 50,
	parameter int ETU_CLKS = 372
) (
	input wire logic clk,
	input wire logic system_reset_low,
	input wire logic [2:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic wr,
	input wire logic rd,
	input wire logic cs,
	input wire logic card_rst,
	input wire logic card_clk,
	input wire logic card_io_out,
	input wire logic card_io_oe
);
	localparam int FRAME = 20 * HALF_CYC * ETU_CLKS;
	logic [31:0] oe_cnt_q;
	wire logic soft_wr = cs && wr && addr == 3'h5;
	default clocking @(posedge clk); endclocking
	default disable iff (!system_reset_low);
	// Counts the cycles the data pin has been driven in the current frame.
	always_ff @(posedge clk) begin
		if (!system_reset_low || !card_io_oe) begin
			oe_cnt_q <= 32'h0;
		end else begin
			oe_cnt_q <= oe_cnt_q + 32'h1;
		end
	end
	sequence s_guard;
		!card_io_oe [*8];
	endsequence
	chk_reset_vals: assert property ($rose(system_reset_low) |-> !card_rst && !card_clk && !card_io_oe)
		else $error("outputs not at defaults after reset");
	chk_rst_write: assert property (soft_wr |=> card_rst == $past(data_in[0]))
		else $error("card reset does not follow bit 0");
	chk_rst_hold: assert property (!soft_wr |=> $stable(card_rst))
		else $error("card reset moved without a write");
	chk_clk_half: assert property (@(posedge clk) disable iff (!system_reset_low || soft_wr)
		$rose(card_clk) |-> ##HALF_CYC $fell(card_clk)) else $error("card clock high time wrong");
	chk_start_low: assert property ($rose(card_io_oe) |-> !card_io_out)
		else $error("frame does not open with a low bit");
	chk_frame_len: assert property ($fell(card_io_oe) && !$past(soft_wr) |-> oe_cnt_q == FRAME)
		else $error("driven part of frame has wrong length");
	chk_guard_idle: assert property ($fell(card_io_oe) && !$past(soft_wr) |-> s_guard)
		else $error("pin driven during guard time");
	chk_read_hole: assert property (cs && rd && addr != 3'h3 && addr != 3'h4 |=> data_out == 8'h00)
		else $error("unmapped read not zero");
	chk_status_pad: assert property (cs && rd && addr == 3'h4 |=> data_out[7:1] == 7'h00)
		else $error("status upper bits not zero");
endmodule // scr_core_sva
bind scr_core scr_core_sva #(.HALF_CYC(HALF_CYC), .ETU_CLKS(ETU_CLKS)) u_sva (.clk(clk),
	.system_reset_low(system_reset_low), .addr(addr), .data_in(data_in), .data_out(data_out), .wr(wr), .rd(rd),
	.cs(cs), .card_rst(card_rst), .card_clk(card_clk), .card_io_out(card_io_out), .card_io_oe(card_io_oe));
`default_nettype wire

// ==== verification/scr_card_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// Behavioural card with an open-drain data pin.
// ****
module scr_card_model #(
	parameter int ETU = 372
) (
	input wire logic card_clk,
	input wire logic io,
	output logic pull_low
);
	logic [7:0] rx_q[$];
	int par_bad = 0;
	bit sending = 0;
	logic [8:0] bits;
	initial pull_low = 1'b0;
	task automatic send(input logic [7:0] b);
		logic [9:0] frame;
		frame = {^b, b, 1'b0};
		sending = 1;
		@(posedge card_clk);
		for (int i = 0; i < 10; i++) begin
			#1;
			pull_low = !frame[i];
			repeat (ETU) @(posedge card_clk);
		end
		#1;
		pull_low = 1'b0;
		repeat (ETU) @(posedge card_clk);
		sending = 0;
	endtask
	// Receives reader characters, sampling each bit in its middle.
	always begin
		@(negedge io);
		if (!sending) begin
			repeat (ETU / 2) @(posedge card_clk);
			for (int i = 0; i < 9; i++) begin
				repeat (ETU) @(posedge card_clk);
				bits[i] = io;
			end
			rx_q.push_back(bits[7:0]);
			if (^bits) par_bad++;
		end
	end
endmodule // scr_card_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int HC = 2;
	localparam int ETU = 4;
	localparam int BITC = 2 * HC * ETU;
	logic clk = 0;
	logic rst_n = 0;
	logic wr = 0;
	logic rd = 0;
	logic cs = 0;
	logic acc;
	logic [2:0] addr = 3'h0;
	logic [7:0] din = 8'h00;
	logic [7:0] d;
	logic [7:0] v;
	wire logic [7:0] dout;
	wire logic rdy, crst, cclk, io_out, io_oe, pull_low;
	wire logic io = (io_oe ? io_out : 1'b1) & !pull_low;
	int err_total = 0;
	int checks_done = 0;
	int seed = 99242;
	logic [7:0] exp_q[$];
	scr_core #(.HALF_CYC(HC), .ETU_CLKS(ETU), .FIFO_DEPTH(8), .FIFO_AW(3)) dut (.clk(clk), .system_reset_low(rst_n),
		.addr(addr), .data_in(din), .data_out(dout), .wr(wr), .rd(rd), .cs(cs), .host_wr_ready(rdy), .card_rst(crst),
		.card_clk(cclk), .card_io_in(io), .card_io_out(io_out), .card_io_oe(io_oe));
	scr_card_model #(.ETU(ETU)) card (.card_clk(cclk), .io(io), .pull_low(pull_low));
	initial forever #5 clk = ~clk;
	// ****
	// Host bus tasks and comparison.
	// ****
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] val);
		@(posedge clk);
		#1;
		cs = 1'b1;
		wr = w;
		rd = !w;
		addr = a;
		din = val;
		acc = rdy;
		@(posedge clk);
		#1;
		cs = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		d = dout;
	endtask
	task automatic wait_done;
		for (int i = 0; i < 400; i++) begin
			bus(0, 3'h4, 8'h00);
			if (d === 8'h01) return;
		end
		chk("done_wait", d, 8'h01);
		end_sim;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1;
		for (int a = 0; a < 8; a++) begin
			bus(0, a[2:0], 8'h00);
			chk("read_reset", d, 8'h00);
		end
		chk("card_rst_reset", {7'h00, crst}, 8'h00);
		bus(1, 3'h5, 8'h00);
		chk("card_rst_low", {7'h00, crst}, 8'h00);
		bus(1, 3'h5, 8'hFF);
		chk("card_rst_high", {7'h00, crst}, 8'h01);
		$display("test reset done");
		repeat (3) begin
			v = 8'($random(seed));
			bus(1, 3'h2, v);
			wait_done;
			bus(0, 3'h4, 8'h00);
			chk("status_tx", d, 8'h01);
			chk("card_rx", card.rx_q.pop_front(), v);
		end
		bus(0, 3'h3, 8'h00);
		bus(0, 3'h4, 8'h00);
		chk("status_clear", d, 8'h00);
		$display("test tx done");
		for (int i = 0; i < 12; i++) begin
			v = 8'($random(seed));
			bus(1, 3'h2, v);
			if (acc) exp_q.push_back(v);
		end
		chk("refused", {7'h00, acc}, 8'h00);
		chk("accepted", 8'(exp_q.size() >= 8), 8'h01);
		for (int i = 0; i < 4000 && card.rx_q.size() < exp_q.size(); i++) @(posedge clk);
		chk("burst_count", 8'(card.rx_q.size()), 8'(exp_q.size()));
		while (exp_q.size() > 0) chk("card_rx_burst", card.rx_q.pop_front(), exp_q.pop_front());
		chk("parity", 8'(card.par_bad), 8'h00);
		repeat (3 * BITC) @(posedge clk);
		bus(0, 3'h4, 8'h00);
		chk("status_burst", d, 8'h01);
		bus(0, 3'h3, 8'h00);
		$display("test burst done");
		repeat (2) begin
			v = 8'($random(seed));
			card.send(v);
			wait_done;
			bus(0, 3'h3, 8'h00);
			chk("incoming", d, v);
			bus(0, 3'h4, 8'h00);
			chk("status_rx_clear", d, 8'h00);
		end
		$display("test rx done");
		bus(1, 3'h2, 8'h5A);
		repeat (3 * BITC) @(posedge clk);
		bus(1, 3'h5, 8'h01);
		chk("abort_oe", {7'h00, io_oe}, 8'h00);
		bus(0, 3'h4, 8'h00);
		chk("abort_status", d, 8'h00);
		repeat (12 * BITC) @(posedge clk);
		bus(0, 3'h4, 8'h00);
		chk("abort_no_done", d, 8'h00);
		card.rx_q.delete();
		$display("test abort done");
		bus(1, 3'h2, 8'hA5);
		repeat (2 * BITC) @(posedge clk);
		#1;
		rst_n = 0;
		repeat (2) @(posedge clk);
		#1;
		chk("reset_pins", {5'h00, crst, cclk, io_oe}, 8'h00);
		chk("reset_dout", dout, 8'h00);
		rst_n = 1;
		bus(0, 3'h4, 8'h00);
		chk("reset_status", d, 8'h00);
		$display("test system reset done");
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
